// ===== tl_logic_tile.sv
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps

module tl_logic_tile (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [7:0]          adr_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [31:0]         dat_i,
	output logic      [31:0]         dat_o,
	output logic                     ack_o,
	input  wire logic [3:0][7:0]     lut_in_i,
	input  wire logic [3:0][1:0]     multipurpose_in_i,
	input  wire logic [3:0]          clk_enable_i,
	input  wire logic [3:0]          local_set_reset_i,
	input  wire logic [3:0]          slice_clk_i,
	input  wire logic                carry_chain_in_i,
	output logic      [3:0]          lut_bypass_out_a_o,
	output logic      [3:0]          lut_bypass_out_b_o,
	output logic      [3:0]          reg_out_a_o,
	output logic      [3:0]          reg_out_b_o,
	output logic      [3:0]          wide_mux_out_low_o,
	output logic      [3:0]          wide_mux_out_high_o,
	output logic                     carry_chain_out_o
);
	import tl_pkg::*;

	logic [31:0] mode_cfg;
	logic [31:0] next_mode_cfg;
	logic [31:0] reg_cfg;
	logic [31:0] next_reg_cfg;
	logic        user_mode;
	logic        next_user_mode;
	logic        ack;
	logic        next_ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [15:0] lut_mem      [TL_SLICES][2];
	logic [15:0] next_lut_mem [TL_SLICES][2];
	logic [3:0][1:0] q;
	logic [3:0][1:0] next_q;
	logic [3:0]  clk_prev;
	logic [3:0]  next_clk_prev;

	wire  [4:0]  chain;
	wire  [3:0]  f0;
	wire  [3:0]  f1;
	wire  [3:0]  wide_mux_out_low;
	wire  [3:0]  cap;
	wire  [3:0]  rip;
	wire  [3:0]  gen_t;
	wire  [3:0]  prop_t;
	wire  [3:0][1:0] d;
	wire  [3:0][2:0] cmp;
	wire  [31:0] status;
	wire         req;
	wire         ram_we;
	wire  [3:0]  ram_addr;
	wire  [3:0]  ram_data;

	function automatic logic [31:0] tl_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// 3-bit result: carry or borrow out on top
	function automatic logic [2:0] tl_arith(input logic [1:0] a,
		input logic [1:0] b, input logic [1:0] qv, input tl_rop_t op,
		input logic ctl, input logic cin);
		logic [2:0] add;
		logic [2:0] sub;
		logic [2:0] r;
		add = {1'b0, a} + {1'b0, b} + {2'h0, cin};
		sub = {1'b0, a} + {1'b0, ~b} + {2'h0, cin};
		r = add;
		unique case (op)
			TL_ROP_ADD:    r = add;
			TL_ROP_SUB:    r = sub;
			TL_ROP_ADDSUB: r = ctl ? add : sub;
			TL_ROP_COUNT:  r = ctl ? {1'b0, qv} + {2'h0, cin}
				: {1'b0, qv} - {2'h0, cin};
		endcase
		return r;
	endfunction

	assign chain[0] = carry_chain_in_i;
	assign req      = cyc_i && stb_i && !ack;

	genvar s;
	generate
		for (s = 0; s < TL_SLICES; s++)
		begin : g_slice
			wire       [3:0] ia;
			wire       [3:0] ib;
			wire       [1:0] opa;
			wire       [1:0] opb;
			wire             fast;
			wire             cin;
			wire             act;
			wire             prev_act;
			wire       [2:0] r;
			wire       [2:0] r0;
			wire       [2:0] r1;
			tl_rop_t         op;
			tl_mode_t        md;

			assign ia  = lut_in_i[s][3:0];
			assign ib  = lut_in_i[s][7:4];
			assign md  = tl_mode_t'(mode_cfg[TL_F_MODE + 2*s +: 2]);
			assign op  = tl_rop_t'(mode_cfg[TL_F_RIPOP + 2*s +: 2]);
			assign rip[s] = (md == TL_MODE_RIPPLE);
			// operands are the A and B pins of both halves
			assign opa = {ib[0], ia[0]};
			assign opb = {ib[1], ia[1]};
			// chain input ignored unless fast carry is enabled
			assign fast = mode_cfg[TL_F_FAST + s] && rip[s];
			assign cin  = fast && chain[s];
			assign r  = tl_arith(opa, opb, q[s], op, ia[2], cin);
			assign r0 = tl_arith(opa, opb, q[s], op, ia[2], 1'b0);
			assign r1 = tl_arith(opa, opb, q[s], op, ia[2], 1'b1);
			assign gen_t[s]  = fast && r0[2];
			assign prop_t[s] = fast && r1[2] && !r0[2];
			assign chain[s+1] = gen_t[s] || (prop_t[s] && chain[s]);
			assign cmp[s] = {opa <= opb, opa != opb, opa >= opb};
			// ROM and RAM read through the same table as logic mode
			assign f0[s] = rip[s] ? r[0] : lut_mem[s][0][ia];
			assign f1[s] = rip[s] ? r[1] : lut_mem[s][1][ib];
			assign wide_mux_out_low[s] = multipurpose_in_i[s][0] ? f1[s] : f0[s];
			// counter preload of operand A when the first mux input is high
			assign d[s] = (rip[s] && op == TL_ROP_COUNT && multipurpose_in_i[s][0])
				? opa : {f1[s], f0[s]};
			assign act      = slice_clk_i[s] ^ reg_cfg[4*s + TL_F_NEG];
			assign prev_act = clk_prev[s] ^ reg_cfg[4*s + TL_F_NEG];
			assign cap[s] = reg_cfg[4*s + TL_F_LATCH] ? act
				: (act && !prev_act);
		end
	endgenerate

	// the low-index tile gates its half with m1; routing ORs the two halves
	assign wide_mux_out_high_o[1] = multipurpose_in_i[1][1] ? wide_mux_out_low[1] : wide_mux_out_low[0];
	assign wide_mux_out_high_o[3] = multipurpose_in_i[3][1] ? wide_mux_out_low[3] : wide_mux_out_low[2];
	assign wide_mux_out_high_o[2] = multipurpose_in_i[2][1]
		? wide_mux_out_high_o[3] : wide_mux_out_high_o[1];
	assign wide_mux_out_high_o[0] = multipurpose_in_i[0][1]
		&& wide_mux_out_high_o[2];

	assign lut_bypass_out_a_o = f0;
	assign lut_bypass_out_b_o = f1;
	assign wide_mux_out_low_o = wide_mux_out_low;
	assign carry_chain_out_o  = chain[4];

	// slice 2 supplies write strobe, address and data for slices 0 and 1
	assign ram_we   = user_mode && cap[2] && local_set_reset_i[2];
	assign ram_addr = lut_in_i[2][3:0];
	assign ram_data = lut_in_i[2][7:4];

	assign status = {cmp, prop_t, gen_t, chain[4:1], q};

	// configuration and bus slave
	always_comb
	begin
		next_mode_cfg  = mode_cfg;
		next_reg_cfg   = reg_cfg;
		next_user_mode = user_mode;
		next_ack       = req;
		next_rdata     = 32'h0000_0000;
		if (req && we_i)
		begin
			unique case (adr_i)
				TL_ADDR_MODE:   next_mode_cfg = tl_merge(mode_cfg, dat_i, sel_i);
				TL_ADDR_REGCFG: next_reg_cfg  = tl_merge(reg_cfg, dat_i, sel_i);
				TL_ADDR_CTRL:   if (sel_i[0]) next_user_mode = dat_i[TL_F_USER];
				default:        next_user_mode = user_mode;
			endcase
		end
		// slice 3 has no RAM: a RAM request for it falls back to logic
		if (next_mode_cfg[TL_F_MODE + 6 +: 2] == TL_MODE_RAM)
		begin
			next_mode_cfg[TL_F_MODE + 6 +: 2] = TL_MODE_LOGIC;
		end
		if (req && !we_i)
		begin
			unique case (adr_i)
				TL_ADDR_MODE:   next_rdata = mode_cfg;
				TL_ADDR_REGCFG: next_rdata = reg_cfg;
				TL_ADDR_CTRL:   next_rdata = {31'h0, user_mode};
				TL_ADDR_STATUS: next_rdata = status;
				default:
				begin
					for (int i = 0; i < TL_SLICES; i++)
					begin
						if (adr_i == TL_ADDR_LUT + 8'(4*i))
						begin
							next_rdata = {lut_mem[i][1], lut_mem[i][0]};
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_cfg  <= TL_RST_MODE;
			reg_cfg   <= TL_RST_REGCFG;
			user_mode <= 1'b0;
			ack       <= 1'b0;
			rdata     <= 32'h0000_0000;
		end
		else
		begin
			mode_cfg  <= next_mode_cfg;
			reg_cfg   <= next_reg_cfg;
			user_mode <= next_user_mode;
			ack       <= next_ack;
			rdata     <= next_rdata;
		end
	end

	assign ack_o = ack;
	assign dat_o = rdata;

	// lookup tables: bus preload and distributed RAM writes
	always_comb
	begin
		for (int i = 0; i < TL_SLICES; i++)
		begin
			next_lut_mem[i][0] = lut_mem[i][0];
			next_lut_mem[i][1] = lut_mem[i][1];
			if (req && we_i && adr_i == TL_ADDR_LUT + 8'(4*i))
			begin
				{next_lut_mem[i][1], next_lut_mem[i][0]} = tl_merge(
					{lut_mem[i][1], lut_mem[i][0]}, dat_i, sel_i);
			end
		end
		// bus preload wins a same-cycle clash with a RAM write
		for (int i = 0; i < 2; i++)
		begin
			if (ram_we && !(req && we_i)
				&& mode_cfg[TL_F_MODE + 2*i +: 2] == TL_MODE_RAM)
			begin
				next_lut_mem[i][0][ram_addr] = ram_data[2*i];
				next_lut_mem[i][1][ram_addr] = ram_data[2*i + 1];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < TL_SLICES; i++)
			begin
				lut_mem[i][0] <= TL_RST_LUT;
				lut_mem[i][1] <= TL_RST_LUT;
			end
		end
		else
		begin
			lut_mem <= next_lut_mem;
		end
	end

	// slice registers; async set/reset acts on the next system edge, the
	// closest a single-clock model gets to a truly asynchronous path
	always_comb
	begin
		next_clk_prev = slice_clk_i;
		for (int i = 0; i < TL_SLICES; i++)
		begin
			next_q[i] = q[i];
			if (!user_mode)
			begin
				next_q[i] = reg_cfg[TL_F_INIT + 2*i +: 2];
			end
			else if (reg_cfg[4*i + TL_F_ASYNC] && local_set_reset_i[i])
			begin
				next_q[i] = reg_cfg[TL_F_INIT + 2*i +: 2];
			end
			else if (cap[i])
			begin
				if (local_set_reset_i[i] && !reg_cfg[4*i + TL_F_ASYNC])
				begin
					next_q[i] = reg_cfg[TL_F_INIT + 2*i +: 2];
				end
				else if (clk_enable_i[i])
				begin
					next_q[i] = d[i];
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q        <= '0;
			clk_prev <= 4'h0;
		end
		else
		begin
			q        <= next_q;
			clk_prev <= next_clk_prev;
		end
	end

	always_comb
	begin
		for (int i = 0; i < TL_SLICES; i++)
		begin
			reg_out_a_o[i] = q[i][0];
			reg_out_b_o[i] = q[i][1];
		end
	end

endmodule

// ===== tl_pkg.sv
package tl_pkg;

	localparam int unsigned TL_SLICES = 4;

	// bus map, byte addresses
	localparam logic [7:0] TL_ADDR_LUT    = 8'h00;
	localparam logic [7:0] TL_ADDR_MODE   = 8'h10;
	localparam logic [7:0] TL_ADDR_REGCFG = 8'h14;
	localparam logic [7:0] TL_ADDR_CTRL   = 8'h18;
	localparam logic [7:0] TL_ADDR_STATUS = 8'h1c;

	// mode register fields
	localparam int unsigned TL_F_MODE  = 0;
	localparam int unsigned TL_F_RIPOP = 8;
	localparam int unsigned TL_F_FAST  = 16;

	// register configuration fields
	localparam int unsigned TL_F_NEG   = 0;
	localparam int unsigned TL_F_LATCH = 1;
	localparam int unsigned TL_F_ASYNC = 2;
	localparam int unsigned TL_F_INIT  = 16;

	// control and status fields
	localparam int unsigned TL_F_USER = 0;
	localparam int unsigned TL_S_Q    = 0;
	localparam int unsigned TL_S_CO   = 8;
	localparam int unsigned TL_S_GEN  = 12;
	localparam int unsigned TL_S_PROP = 16;
	localparam int unsigned TL_S_CMP  = 20;

	// reset values
	localparam logic [31:0] TL_RST_MODE   = 32'h0000_0000;
	localparam logic [31:0] TL_RST_REGCFG = 32'h0000_0000;
	localparam logic [15:0] TL_RST_LUT    = 16'h0000;

	typedef enum logic [1:0] {
		TL_MODE_LOGIC  = 2'h0,
		TL_MODE_RIPPLE = 2'h1,
		TL_MODE_RAM    = 2'h3,
		TL_MODE_ROM    = 2'h2
	} tl_mode_t;

	typedef enum logic [1:0] {
		TL_ROP_ADD    = 2'h0,
		TL_ROP_SUB    = 2'h1,
		TL_ROP_ADDSUB = 2'h3,
		TL_ROP_COUNT  = 2'h2
	} tl_rop_t;

endpackage

// ===== tl_fabric_model.sv
`timescale 1ns/10ps
module tl_fabric_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] pulse_i,
	output logic      [3:0] slice_clk_o
);
	// a requested slice clock is high two cycles, then stands low like a gated fabric clock
	logic [3:0][1:0] cnt;
	always_ff @(posedge clk_i)
		for (int s = 0; s < 4; s++)
			if (rst_i)
				cnt[s] <= 2'h0;
			else if (pulse_i[s])
				cnt[s] <= 2'h2;
			else if (cnt[s] != 2'h0)
				cnt[s] <= cnt[s] - 2'h1;
	always_comb
		for (int s = 0; s < 4; s++)
			slice_clk_o[s] = cnt[s] != 2'h0;
endmodule

// ===== tl_logic_tile_assertions.sv
`timescale 1ns/10ps
module tl_tile_chk
	import tl_pkg::*;
(
	input wire logic            clk_i,
	input wire logic            rst_i,
	input wire logic            cyc_i,
	input wire logic            stb_i,
	input wire logic            we_i,
	input wire logic [7:0]      adr_i,
	input wire logic [31:0]     dat_i,
	input wire logic [31:0]     dat_o,
	input wire logic            ack_o,
	input wire logic [3:0][1:0] multipurpose_in_i,
	input wire logic [3:0]      clk_enable_i,
	input wire logic [3:0]      local_set_reset_i,
	input wire logic [3:0]      lut_bypass_out_a_o,
	input wire logic [3:0]      lut_bypass_out_b_o,
	input wire logic [3:0]      reg_out_a_o,
	input wire logic [3:0]      wide_mux_out_low_o,
	input wire logic [3:0]      wide_mux_out_high_o,
	input wire logic            carry_chain_out_o
);
	logic [31:0] mode_seen;
	logic [31:0] next_mode_seen;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// shadow of the mode word, so the low mux check only runs while slice 0 is in logic mode
	always_comb
	begin
		next_mode_seen = mode_seen;
		if (cyc_i && stb_i && we_i && !ack_o && adr_i == TL_ADDR_MODE)
			next_mode_seen = dat_i;
	end
	always_ff @(posedge clk_i)
		mode_seen <= rst_i ? 32'h0 : next_mode_seen;
	property p_ack_next;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("request not answered");
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_dat_idle;
		$fell(ack_o) |-> dat_o == 32'h0 [*2];
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside answer");
	property p_low_mux;
		mode_seen[1:0] == 2'h0 |-> wide_mux_out_low_o[0] ==
			(multipurpose_in_i[0][0] ? lut_bypass_out_b_o[0] : lut_bypass_out_a_o[0]);
	endproperty
	a_low_mux: assert property (p_low_mux) else $error("low wide mux wrong");
	property p_high_mid;
		wide_mux_out_high_o[1] ==
			(multipurpose_in_i[1][1] ? wide_mux_out_low_o[1] : wide_mux_out_low_o[0]);
	endproperty
	a_high_mid: assert property (p_high_mid) else $error("six input mux wrong");
	property p_high_top;
		wide_mux_out_high_o[0] == (multipurpose_in_i[0][1] & wide_mux_out_high_o[2]);
	endproperty
	a_high_top: assert property (p_high_top) else $error("eight input half wrong");
	property p_carry_off;
		!mode_seen[TL_F_FAST+3] |-> !carry_chain_out_o;
	endproperty
	a_carry_off: assert property (p_carry_off) else $error("carry out while off");
	property p_hold;
		(!clk_enable_i[0] && !local_set_reset_i[0] && !cyc_i) [*3] |-> $stable(reg_out_a_o[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("register moved without enable");
endmodule
bind tl_logic_tile tl_tile_chk u_tl_tile_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.multipurpose_in_i(multipurpose_in_i), .clk_enable_i(clk_enable_i),
	.local_set_reset_i(local_set_reset_i), .lut_bypass_out_a_o(lut_bypass_out_a_o),
	.lut_bypass_out_b_o(lut_bypass_out_b_o), .reg_out_a_o(reg_out_a_o),
	.wide_mux_out_low_o(wide_mux_out_low_o), .wide_mux_out_high_o(wide_mux_out_high_o),
	.carry_chain_out_o(carry_chain_out_o));

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import tl_pkg::*;
	localparam logic [15:0] LA = 16'h8ce1;
	localparam logic [15:0] LB = 16'h6996;
	logic            clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cin, cout, c, add;
	logic [7:0]      adr_i;
	logic [3:0]      sel_i, ce, local_set_reset, sclk, pul, bya, byb, qa, qb, wlo, whi;
	logic [31:0]     dat_i, dat_o, rd;
	logic [3:0][7:0] lut;
	logic [3:0][1:0] mp;
	logic [1:0]      a, b, s;
	int              fail_count, check_count;
	tl_logic_tile u_tl_logic_tile (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.lut_in_i(lut), .multipurpose_in_i(mp), .clk_enable_i(ce), .local_set_reset_i(local_set_reset),
		.slice_clk_i(sclk), .carry_chain_in_i(cin), .lut_bypass_out_a_o(bya),
		.lut_bypass_out_b_o(byb), .reg_out_a_o(qa), .reg_out_b_o(qb),
		.wide_mux_out_low_o(wlo), .wide_mux_out_high_o(whi), .carry_chain_out_o(cout));
	tl_fabric_model u_tl_fabric_model (.clk_i(clk_i), .rst_i(rst_i), .pulse_i(pul),
		.slice_clk_o(sclk));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= ad;
		dat_i <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n == 20)
		begin
			fail_count++;
			test_done();
		end
		@(posedge clk_i);
	endtask
	task automatic rdx(input logic [7:0] ad, input logic [31:0] e);
		wb(1'b0, ad, 32'h0);
		chk(rd, e);
	endtask
	// the fabric model needs one cycle to raise the clock, the tile one more to show it
	task automatic pulse(input int sl);
		pul[sl] <= 1'b1;
		@(posedge clk_i);
		pul <= 4'h0;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic ramw(input logic [7:0] v, input logic en);
		lut[2] <= v;
		local_set_reset <= {1'b0, en, 2'b0};
		pulse(2);
		local_set_reset <= 4'h0;
		// one idle edge so a following call never re-drives lsr in this time step
		@(posedge clk_i);
	endtask
	initial
	begin
		{cyc_i, stb_i, we_i, cin, adr_i, dat_i, lut, mp, ce, local_set_reset, pul} = '0;
		sel_i = 4'hf;
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rdx(TL_ADDR_MODE, TL_RST_MODE);
		rdx(TL_ADDR_REGCFG, TL_RST_REGCFG);
		rdx(TL_ADDR_LUT, {16'h0, TL_RST_LUT});
		wb(1'b1, 8'h40, 32'hffff_ffff);
		rdx(8'h40, 32'h0);
		wb(1'b1, TL_ADDR_MODE, 32'h0000_00c0);
		rdx(TL_ADDR_MODE, 32'h0);
		$display("test registers done");
		wb(1'b1, TL_ADDR_LUT, {LB, LA});
		for (int i = 0; i < 16; i++)
		begin
			lut[0] <= {i[3:0], i[3:0]};
			mp[0] <= {1'b0, i[0]};
			@(posedge clk_i);
			chk({byb[0], bya[0]}, {LB[i], LA[i]});
			chk(wlo[0], i[0] ? LB[i] : LA[i]);
		end
		$display("test logic done");
		wb(1'b1, TL_ADDR_REGCFG, 32'h0001_0000);
		chk(qa[0], 1'b1);
		wb(1'b1, TL_ADDR_CTRL, 32'h1);
		lut[0] <= 8'h11;
		ce <= 4'h1;
		pulse(0);
		chk({qb[0], qa[0]}, 2'b10);
		ce <= 4'h0;
		lut[0] <= 8'h00;
		pulse(0);
		chk({qb[0], qa[0]}, 2'b10);
		local_set_reset <= 4'h1;
		pulse(0);
		chk({qb[0], qa[0]}, 2'b01);
		wb(1'b1, TL_ADDR_REGCFG, 32'h0001_0004);
		local_set_reset <= 4'h0;
		ce <= 4'h1;
		lut[0] <= 8'h11;
		pulse(0);
		local_set_reset <= 4'h1;
		repeat (3) @(posedge clk_i);
		chk({qb[0], qa[0]}, 2'b01);
		local_set_reset <= 4'h0;
		$display("test slice registers done");
		wb(1'b1, TL_ADDR_MODE, 32'h0000_003f);
		ce <= 4'h4;
		ramw(8'ha5, 1'b1);
		ramw(8'h69, 1'b1);
		ramw(8'h05, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			lut[0] <= i ? 8'h99 : 8'h55;
			lut[1] <= i ? 8'h99 : 8'h55;
			@(posedge clk_i);
			chk({byb[1], bya[1], byb[0], bya[0]}, i ? 4'h6 : 4'ha);
		end
		$display("test memory done");
		for (int op = 0; op < 4; op++)
		begin
			if (op == 2)
				continue;
			wb(1'b1, TL_ADDR_MODE, 32'h0001_0001 | (op << 8));
			for (int v = 0; v < 16; v++)
			begin
				{b, a} = v[3:0];
				c = v[0] ^ v[3];
				add = op == 0 || (op == 3 && c);
				lut[0] <= {2'b0, b[1], a[1], 1'b0, c, b[0], a[0]};
				cin <= !add;
				wb(1'b0, TL_ADDR_STATUS, 32'h0);
				s = add ? a + b : a - b;
				chk({byb[0], bya[0]}, s);
				chk(rd[22:20], {a <= b, a != b, a >= b});
				chk(rd[8], add ? (int'(a) + int'(b) > 3) : (a >= b));
				chk(cout, 1'b0);
			end
		end
		$display("test ripple done");
		// slice 0 counter: fast carry on so the carry input is the count step
		wb(1'b1, TL_ADDR_MODE, 32'h0001_0201);
		wb(1'b1, TL_ADDR_REGCFG, 32'h0000_0004);
		ce <= 4'h1;
		cin <= 1'b1;
		lut[0] <= 8'h14;
		mp[0] <= 2'b01;
		pulse(0);
		chk({qb[0], qa[0]}, 2'b10);
		mp[0] <= 2'b00;
		pulse(0);
		chk({qb[0], qa[0]}, 2'b11);
		lut[0] <= 8'h10;
		pulse(0);
		chk({qb[0], qa[0]}, 2'b10);
		local_set_reset <= 4'h1;
		repeat (2) @(posedge clk_i);
		chk({qb[0], qa[0]}, 2'b00);
		local_set_reset <= 4'h0;
		$display("test counter done");
		test_done();
	end
endmodule
